/* File: hw/posm_pkg.sv */
/*
  posm_pkg: register offsets, field positions, reset values and code points
  of the three-pin output source selector.
  Assumes: an 8-bit register access port supplied by the serial control bus
  decoder of the enclosing device.
*/
package posm_pkg;

  localparam int unsigned NUM_PINS    = 3;
  localparam int unsigned NUM_PORTS   = 2;
  localparam int unsigned REMOTE_PINS = 4;
  localparam int unsigned LEVEL_PINS  = 4;

  localparam logic [7:0] PIN0_CTRL_OFFSET   = 8'h10;
  localparam logic [7:0] PIN1_CTRL_OFFSET   = 8'h11;
  localparam logic [7:0] PIN2_CTRL_OFFSET   = 8'h12;
  localparam logic [7:0] LEVEL_STATUS_OFFSET = 8'h0E;
  localparam logic [7:0] PIN_CTRL_RESET     = 8'h00;

  localparam int unsigned SEL_MSB = 7;
  localparam int unsigned SEL_LSB = 5;
  localparam int unsigned SRC_MSB = 4;
  localparam int unsigned SRC_LSB = 2;
  localparam int unsigned VAL_BIT = 1;
  localparam int unsigned EN_BIT  = 0;

  localparam logic [2:0] SRC_PORT0  = 3'h0;
  localparam logic [2:0] SRC_PORT1  = 3'h1;
  localparam logic [2:0] SRC_STATUS = 3'h4;

  localparam logic [2:0] SEL_REMOTE_MAX = 3'h3;
  localparam logic [2:0] SEL_PORT_LOCK  = 3'h4;
  localparam logic [2:0] SEL_PORT_PASS  = 3'h5;

  localparam logic [2:0] SEL_LOCAL_VAL  = 3'h0;
  localparam logic [2:0] SEL_LOCK_ANY   = 3'h1;
  localparam logic [2:0] SEL_LOCK_ALL   = 3'h2;
  localparam logic [2:0] SEL_PASS_ALL   = 3'h3;
  localparam logic [2:0] SEL_FRAME      = 3'h4;

  typedef struct packed {
    logic [SEL_MSB-SEL_LSB:0] output_select;
    logic [SRC_MSB-SRC_LSB:0] output_source;
    logic                     local_value;
    logic                     driver_enable;
  } posm_pin_ctrl_t;

  // per-port status forwarded from the link receivers
  typedef struct packed {
    logic [REMOTE_PINS-1:0] remote_pins;
    logic                   lock;
    logic                   pass;
    logic                   enabled;
  } posm_port_stat_t;

  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } posm_reg_req_t;

endpackage : posm_pkg

/* File: hw/posm_pin_select.sv */
/*
  posm_pin_select: output source selection for one pin, purely combinational.
  Assumes: control fields held in flip-flops by the parent; status inputs are
  already in the core clock domain.
*/
`timescale 1ns/100ps
module posm_pin_select
(
  input  wire posm_pkg::posm_pin_ctrl_t                       ctrl_i,
  input  wire posm_pkg::posm_port_stat_t [posm_pkg::NUM_PORTS-1:0] port_i,
  input  wire logic                                           frame_pulse_i,
  output logic                                                level_o,
  output logic                                                drive_o
);

  logic                    lock_any;
  logic                    lock_all;
  logic                    pass_all;
  posm_pkg::posm_port_stat_t chosen;

  always_comb
  begin
    lock_any = 1'b0;
    lock_all = 1'b1;
    pass_all = 1'b1;
    for (int p = 0; p < posm_pkg::NUM_PORTS; p++)
    begin
      // disabled ports drop out of the combination entirely
      if (port_i[p].enabled)
      begin
        lock_any = lock_any | port_i[p].lock;
        lock_all = lock_all & port_i[p].lock;
        pass_all = pass_all & port_i[p].pass;
      end
    end
    chosen  = (ctrl_i.output_source == posm_pkg::SRC_PORT1) ? port_i[1] : port_i[0];
    level_o = 1'b0;
    if (ctrl_i.output_source == posm_pkg::SRC_PORT0 || ctrl_i.output_source == posm_pkg::SRC_PORT1)
    begin
      if (ctrl_i.output_select <= posm_pkg::SEL_REMOTE_MAX)
        level_o = chosen.remote_pins[ctrl_i.output_select[1:0]];
      else if (ctrl_i.output_select == posm_pkg::SEL_PORT_LOCK)
        level_o = chosen.lock;
      else if (ctrl_i.output_select == posm_pkg::SEL_PORT_PASS)
        level_o = chosen.pass;
    end
    else if (ctrl_i.output_source == posm_pkg::SRC_STATUS)
    begin
      case (ctrl_i.output_select)
        posm_pkg::SEL_LOCAL_VAL: level_o = ctrl_i.local_value;
        posm_pkg::SEL_LOCK_ANY:  level_o = lock_any;
        posm_pkg::SEL_LOCK_ALL:  level_o = lock_all;
        posm_pkg::SEL_PASS_ALL:  level_o = pass_all;
        posm_pkg::SEL_FRAME:     level_o = frame_pulse_i;
        default:                 level_o = 1'b0;
      endcase
    end
    drive_o = ctrl_i.driver_enable;
  end

endmodule : posm_pin_select

/* File: hw/posm_top.sv */
/*
  posm_top: control registers and output drivers for pins 0 to 2, plus the
  read-only live pin level status.
  Layout: one byte of control per pin (select 7:5, source 4:2, local value 1,
  driver enable 0) and one status byte holding the settled pad levels in 3:0.
  Timing: a write lands on the edge that takes it; the pads follow one edge
  later. A read answers one edge after its strobe, for one cycle only. A pad
  level shows in the status byte four edges after it settles on the pin.
  Assumes: the serial control bus decoder presents single-cycle 8-bit read and
  write strobes in the core clock domain; pins are open three-signal pads;
  receive port status and the frame pulse already run on the core clock.
  Limits: reserved codes drive a low level, not a released pad, and the lock
  and pass combinations are computed per pin rather than shared.
*/
// Behaviour
// - source field bits 4:2 picks port 0, port 1 or device status.
// - port source, select 0..3 routes that port's remote pin 0..3.
// - port source, select 4 gives port lock, 5 gives port pass.
// - status source, select 0 drives the register's local value bit.
// - status source, select 1 gives OR of enabled ports' lock.
// - status source, select 2 gives AND of enabled ports' lock.
// - status source, select 3 gives AND of enabled ports' pass.
// - status source, select 4 drives the frame pulse; higher reserved.
// - bit 0 enables the pin driver; only then does source reach pin.
// - all control fields read/write, reset zero: drivers off, port 0.
// - read-only status returns live level of each pin, bit n pin n.
`timescale 1ns/100ps
module posm_top
#(
  parameter int unsigned NUM_PINS = posm_pkg::NUM_PINS
)
(
  input  wire logic                                           clk_i,
  input  wire logic                                           srst_i,
  input  wire posm_pkg::posm_reg_req_t                        req_i,
  output logic [7:0]                                          rdata_o,
  output logic                                                rvalid_o,
  input  wire posm_pkg::posm_port_stat_t [posm_pkg::NUM_PORTS-1:0] port_i,
  input  wire logic                                           frame_pulse_i,
  input  wire logic [posm_pkg::LEVEL_PINS-1:0]                pin_level_i,
  output logic [NUM_PINS-1:0]                                 pin_o,
  output logic [NUM_PINS-1:0]                                 pin_oe_n_o
);

  typedef posm_pkg::posm_pin_ctrl_t [NUM_PINS-1:0] posm_ctrl_arr_t;

  typedef struct packed {
    posm_ctrl_arr_t                          ctrl;
    logic [posm_pkg::LEVEL_PINS-1:0]         sync1;
    logic [posm_pkg::LEVEL_PINS-1:0]         sync2;
    logic [posm_pkg::LEVEL_PINS-1:0]         sync3;
    logic [posm_pkg::LEVEL_PINS-1:0]         level;
    logic [NUM_PINS-1:0]                     pin;
    logic [NUM_PINS-1:0]                     oe_n;
    logic [7:0]                              rdata;
    logic                                    rvalid;
  } posm_state_t;

  posm_state_t         state_q;
  posm_state_t         state_d;
  logic [NUM_PINS-1:0] sel_level;
  logic [NUM_PINS-1:0] sel_drive;

  // maps a bus address to a pin index, NUM_PINS when none matches
  function automatic int unsigned pin_index(input logic [7:0] addr);
    if (addr == posm_pkg::PIN0_CTRL_OFFSET)
      return 0;
    else if (addr == posm_pkg::PIN1_CTRL_OFFSET)
      return 1;
    else if (addr == posm_pkg::PIN2_CTRL_OFFSET)
      return 2;
    else
      return NUM_PINS;
  endfunction : pin_index

  // splits a bus byte into control fields at their register bit positions
  function automatic posm_pkg::posm_pin_ctrl_t ctrl_from_byte(input logic [7:0] data);
    posm_pkg::posm_pin_ctrl_t ctrl;
    ctrl.output_select = data[posm_pkg::SEL_MSB:posm_pkg::SEL_LSB];
    ctrl.output_source = data[posm_pkg::SRC_MSB:posm_pkg::SRC_LSB];
    ctrl.local_value   = data[posm_pkg::VAL_BIT];
    ctrl.driver_enable = data[posm_pkg::EN_BIT];
    return ctrl;
  endfunction : ctrl_from_byte

  // packs control fields back into the byte a read returns
  function automatic logic [7:0] ctrl_to_byte(input posm_pkg::posm_pin_ctrl_t ctrl);
    logic [7:0] data;
    data                                      = 8'h00;
    data[posm_pkg::SEL_MSB:posm_pkg::SEL_LSB] = ctrl.output_select;
    data[posm_pkg::SRC_MSB:posm_pkg::SRC_LSB] = ctrl.output_source;
    data[posm_pkg::VAL_BIT]                   = ctrl.local_value;
    data[posm_pkg::EN_BIT]                    = ctrl.driver_enable;
    return data;
  endfunction : ctrl_to_byte

  // status byte: settled levels low, reserved upper bits zero
  function automatic logic [7:0] level_byte(input logic [posm_pkg::LEVEL_PINS-1:0] level);
    logic [7:0] data;
    data                           = 8'h00;
    data[posm_pkg::LEVEL_PINS-1:0] = level;
    return data;
  endfunction : level_byte

  // a bit moves only once the last two stages agree, so a metastable flip never counts
  function automatic logic [posm_pkg::LEVEL_PINS-1:0] settle_levels
  (
    input logic [posm_pkg::LEVEL_PINS-1:0] held,
    input logic [posm_pkg::LEVEL_PINS-1:0] mid,
    input logic [posm_pkg::LEVEL_PINS-1:0] last
  );
    logic [posm_pkg::LEVEL_PINS-1:0] settled;
    settled = held;
    for (int b = 0; b < posm_pkg::LEVEL_PINS; b++)
    begin
      if (mid[b] == last[b])
        settled[b] = last[b];
    end
    return settled;
  endfunction : settle_levels

  // pad level is masked while the driver is off, so a released pad never shows a stale high
  function automatic logic [1:0] pad_pair
  (
    input logic level,
    input logic drive
  );
    logic [1:0] pair;
    pair[1] = level & drive;
    pair[0] = ~drive;
    return pair;
  endfunction : pad_pair

  // only the three control bytes take writes; the status byte is read-only
  function automatic posm_ctrl_arr_t apply_write
  (
    input posm_ctrl_arr_t          ctrl,
    input posm_pkg::posm_reg_req_t req
  );
    posm_ctrl_arr_t ctrl_upd;
    int unsigned    idx;
    ctrl_upd = ctrl;
    idx      = pin_index(req.addr);
    if (req.wr_en && idx < NUM_PINS)
      ctrl_upd[idx] = ctrl_from_byte(req.wdata);
    return ctrl_upd;
  endfunction : apply_write

  // read data for one address; unmapped bytes read as zero
  function automatic logic [7:0] read_data
  (
    input logic [7:0]  addr,
    input posm_state_t state
  );
    logic [7:0]  data;
    int unsigned idx;
    data = 8'h00;
    idx  = pin_index(addr);
    if (idx < NUM_PINS)
      data = ctrl_to_byte(state.ctrl[idx]);
    else if (addr == posm_pkg::LEVEL_STATUS_OFFSET)
      data = level_byte(state.level);
    return data;
  endfunction : read_data

  generate
    for (genvar g = 0; g < NUM_PINS; g++)
    begin : g_pin
      posm_pin_select u_sel
      (
        .ctrl_i        (state_q.ctrl[g]),
        .port_i        (port_i),
        .frame_pulse_i (frame_pulse_i),
        .level_o       (sel_level[g]),
        .drive_o       (sel_drive[g])
      );
    end
  endgenerate

  always_comb
  begin
    state_d = state_q;
    // bus side: a read in the same cycle as a write still returns the old byte
    state_d.ctrl   = apply_write(state_q.ctrl, req_i);
    state_d.rvalid = req_i.rd_en;
    state_d.rdata  = 8'h00;
    if (req_i.rd_en)
      state_d.rdata = read_data(req_i.addr, state_q);
    // pin level synchroniser, three stages
    state_d.sync1 = pin_level_i;
    state_d.sync2 = state_q.sync1;
    state_d.sync3 = state_q.sync2;
    state_d.level = settle_levels(state_q.level, state_q.sync2, state_q.sync3);
    // pad stage, registered so the pads never glitch on a select change
    for (int p = 0; p < NUM_PINS; p++)
    begin
      {state_d.pin[p], state_d.oe_n[p]} = pad_pair(sel_level[p], sel_drive[p]);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      for (int p = 0; p < NUM_PINS; p++)
        state_q.ctrl[p] <= posm_pkg::PIN_CTRL_RESET;
      state_q.sync1  <= '0;
      state_q.sync2  <= '0;
      state_q.sync3  <= '0;
      state_q.level  <= '0;
      state_q.pin    <= '0;
      state_q.oe_n   <= '1;
      state_q.rdata  <= 8'h00;
      state_q.rvalid <= 1'b0;
    end
    else
      state_q <= state_d;
  end

  assign rdata_o    = state_q.rdata;
  assign rvalid_o   = state_q.rvalid;
  assign pin_o      = state_q.pin;
  assign pin_oe_n_o = state_q.oe_n;

endmodule : posm_top

/* File: verification/posm_asserts.sv */
/* posm_asserts: port checks of the pin output selector.
   Assumes: bound into posm_top, one clock, sync reset. */
`timescale 1ns/100ps
module posm_asserts
#(
  parameter int unsigned NUM_PINS = 3
)
(
  input wire logic                    clk_i,
  input wire logic                    srst_i,
  input wire posm_pkg::posm_reg_req_t req_i,
  input wire logic [7:0]              rdata_o,
  input wire logic                    rvalid_o,
  input wire posm_pkg::posm_port_stat_t [posm_pkg::NUM_PORTS-1:0] port_i,
  input wire logic                    frame_pulse_i,
  input wire logic [NUM_PINS-1:0]     pin_o,
  input wire logic [NUM_PINS-1:0]     pin_oe_n_o
);
  // shadow of the control registers, taken from the bus alone
  logic [7:0] sh_q [3];
  always_ff @(posedge clk_i)
  begin
    for (int i = 0; i < 3; i++)
    begin
      if (srst_i)
        sh_q[i] <= 8'h00;
      else if (req_i.wr_en && req_i.addr == 8'h10 + 8'(i))
        sh_q[i] <= req_i.wdata;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  a_read_answer: assert property (req_i.rd_en |=> rvalid_o) else $error("no read answer");
  a_read_back: assert property (req_i.rd_en && req_i.addr == 8'h10 |=> rdata_o == $past(sh_q[0]))
    else $error("readback wrong");
  a_read_quiet: assert property (!req_i.rd_en |=> !rvalid_o && rdata_o == 8'h00)
    else $error("stray read answer");
  a_status_upper: assert property (req_i.rd_en && req_i.addr == 8'h0E |=> rdata_o[7:4] == 4'h0)
    else $error("status upper bits");
  a_off_low: assert property ((pin_o & pin_oe_n_o) == '0) else $error("disabled pin high");
  a_enable_follow: assert property (1'b1 |=> pin_oe_n_o == ~$past({sh_q[2][0], sh_q[1][0], sh_q[0][0]}))
    else $error("enable wrong");
  a_frame_pin: assert property (sh_q[1] == 8'h91 |=> pin_o[1] == $past(frame_pulse_i))
    else $error("frame pin");
  a_local_value: assert property (sh_q[0][7:2] == 6'h04 && sh_q[0][0] |=> pin_o[0] == $past(sh_q[0][1]))
    else $error("local value");
  a_remote_route: assert property (sh_q[2][7:0] inside {8'h05, 8'h25, 8'h45, 8'h65}
    |=> pin_o[2] == $past(port_i[1].remote_pins[sh_q[2][6:5]])) else $error("remote route");
  a_reserved_low: assert property (sh_q[0][4:3] == 2'b01 || sh_q[0][4:2] > 3'h4 |=> !pin_o[0])
    else $error("reserved not low");
  c_frame: cover property (sh_q[1] == 8'h91 && frame_pulse_i);
  c_status: cover property (req_i.rd_en && req_i.addr == 8'h0E);
  c_readback: cover property (rvalid_o && rdata_o != 8'h00);
endmodule : posm_asserts

/* File: verification/posm_serializer_model.sv */
/* posm_serializer_model: far-end serializer forwarding remote states.
   Assumes: new states are produced only when the bench asks. */
`timescale 1ns/100ps
module posm_serializer_model
(
  input  wire logic                                    clk_i,
  input  wire logic                                    upd_i,
  output posm_pkg::posm_port_stat_t [posm_pkg::NUM_PORTS-1:0] port_o
);
  integer      seed = 32'h5A3C0F17;
  logic [31:0] r;
  initial port_o = '0;
  // states hold between requests so a check sees a settled input
  always @(posedge clk_i)
  begin
    if (upd_i)
    begin
      r = $random(seed);
      #1 port_o = r[$bits(port_o)-1:0];
    end
  end
endmodule : posm_serializer_model

/* File: verification/tb.sv */
/* tb: self-checking bench of posm_top against a behavioural model.
   Assumes: posm_pkg, checker and serializer model compiled first. */
`timescale 1ns/100ps
module tb;
  localparam int unsigned NUM_PINS = 3;
  logic                    clk_i = 1'b0;
  logic                    srst_i = 1'b1;
  posm_pkg::posm_reg_req_t req = '0;
  logic [7:0]              rdata;
  logic                    rvalid;
  posm_pkg::posm_port_stat_t [posm_pkg::NUM_PORTS-1:0] port;
  logic                    frame = 1'b0;
  logic                    upd = 1'b0;
  logic [3:0]              level = 4'h0;
  logic [NUM_PINS-1:0]     pin;
  logic [NUM_PINS-1:0]     oe_n;
  logic [7:0]              ctl [3] = '{8'h00, 8'h00, 8'h00};
  integer                  seed = 32'hF029160D;
  int                      fail_count = 0;
  int                      samples_checked = 0;
  initial forever #10 clk_i = ~clk_i;
  posm_serializer_model u_far (.clk_i(clk_i), .upd_i(upd), .port_o(port));
  posm_top #(.NUM_PINS(NUM_PINS)) dut (.clk_i(clk_i), .srst_i(srst_i), .req_i(req), .rdata_o(rdata),
    .rvalid_o(rvalid), .port_i(port), .frame_pulse_i(frame), .pin_level_i(level), .pin_o(pin), .pin_oe_n_o(oe_n));
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1 req = '{wr_en: wr, rd_en: !wr, addr: a, wdata: d};
    @(posedge clk_i);
    #1 req = '0;
  endtask : cyc
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    cyc(1'b0, a, 8'h00);
    chk({rvalid, rdata}, {1'b1, e});
  endtask : rd
  function automatic logic [1:0] model(input logic [7:0] c);
    logic v;
    logic any;
    logic all_l;
    logic all_p;
    any = (port[0].lock & port[0].enabled) | (port[1].lock & port[1].enabled);
    all_l = (port[0].lock | ~port[0].enabled) & (port[1].lock | ~port[1].enabled);
    all_p = (port[0].pass | ~port[0].enabled) & (port[1].pass | ~port[1].enabled);
    v = 1'b0;
    if (c[4:2] < 3'h2)
      v = c[7] ? (c[7:5] == 3'h4 ? port[c[2]].lock : c[7:5] == 3'h5 && port[c[2]].pass)
               : port[c[2]].remote_pins[c[6:5]];
    else if (c[4:2] == 3'h4)
      v = c[7:5] == 3'h0 ? c[1] : c[7:5] == 3'h1 ? any : c[7:5] == 3'h2 ? all_l
        : c[7:5] == 3'h3 ? all_p : c[7:5] == 3'h4 && frame;
    return {c[0] & v, ~c[0]};
  endfunction : model
  task automatic chk_pins;
    logic [8:0] e;
    e = '0;
    for (int i = 0; i < 3; i++)
      {e[i+3], e[i]} = model(ctl[i]);
    chk({3'h0, pin, oe_n}, e);
  endtask : chk_pins
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  initial
  begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    report_and_stop();
  end
  initial
  begin
    repeat (10) @(posedge clk_i);
    #1 srst_i = 1'b0;
    level = 4'($random(seed));
    chk_pins();
    rd(8'h10, 8'h00);
    for (int k = 0; k < 768; k++)
    begin
      cyc(1'b1, 8'h10 + 8'(k / 256), 8'(k));
      ctl[k / 256] = 8'(k);
      upd = 1'b1;
      frame = 1'($random(seed));
      @(posedge clk_i);
      #1 upd = 1'b0;
      @(posedge clk_i);
      #1 chk_pins();
      rd(8'h10 + 8'(k / 256), 8'(k));
    end
    cyc(1'b1, 8'h0E, 8'hFF);
    rd(8'h0E, {4'h0, level});
    level = ~level;
    repeat (4) @(posedge clk_i);
    rd(8'h0E, {4'h0, level});
    rd(8'h13, 8'h00);
    @(posedge clk_i);
    #1 srst_i = 1'b1;
    ctl = '{8'h00, 8'h00, 8'h00};
    @(posedge clk_i);
    #1 srst_i = 1'b0;
    @(posedge clk_i);
    #1 chk_pins();
    rd(8'h12, 8'h00);
    report_and_stop();
  end
endmodule : tb
bind posm_top posm_asserts #(.NUM_PINS(NUM_PINS)) u_chk (.clk_i(clk_i), .srst_i(srst_i), .req_i(req_i),
  .rdata_o(rdata_o), .rvalid_o(rvalid_o), .port_i(port_i), .frame_pulse_i(frame_pulse_i), .pin_o(pin_o),
  .pin_oe_n_o(pin_oe_n_o));
